// >>> nsh_pkg.sv
// package with the host controller's register map, nand commands and timing counts
package nsh_pkg;
    // wishbone register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STAT = 8'h04;
    localparam logic [7:0] ADDR_ROW = 8'h08;
    localparam logic [7:0] ADDR_RESULT = 8'h0C;
    localparam logic [7:0] ADDR_UID = 8'h10;
    localparam logic [7:0] ADDR_PARAM = 8'h14;
    localparam logic [7:0] ADDR_PROG = 8'h18;
    // control register opcode field
    localparam int CTRL_OP_LSB = 0;
    localparam int CTRL_OP_W = 3;
    localparam int CTRL_GO_BIT = 31;
    localparam logic [2:0] OP_STATUS = 3'h1;
    localparam logic [2:0] OP_STATUS_ENH = 3'h2;
    localparam logic [2:0] OP_READ_MODE = 3'h3;
    localparam logic [2:0] OP_UID_CHECK = 3'h4;
    localparam logic [2:0] OP_PARAM_TIMES = 3'h5;
    localparam logic [2:0] OP_PROG_CHECK = 3'h6;
    localparam logic [2:0] OP_RESET = 3'h7;
    // nand command codes
    localparam logic [7:0] CMD_READ_MODE = 8'h00;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_STATUS_ENH = 8'h78;
    localparam logic [7:0] CMD_UNIQUE_ID = 8'hED;
    localparam logic [7:0] CMD_PARAM = 8'hEC;
    localparam logic [7:0] CMD_RESET = 8'hFF;
    // status byte fields
    localparam int SB_FAIL = 0;
    localparam int SB_PLANE_FAIL = 1;
    localparam int SB_ARRAY_RDY = 5;
    localparam int SB_READY = 6;
    localparam int SB_NOT_WP = 7;
    // parameter page timing fields (byte index of low byte)
    localparam logic [9:0] PP_TPROG = 10'd133;
    localparam logic [9:0] PP_TERASE = 10'd135;
    localparam logic [9:0] PP_TREAD = 10'd137;
    localparam logic [9:0] PP_VREV = 10'd164;
    localparam logic [9:0] PP_COPY_LEN = 10'd256;
    // unique id page layout
    localparam logic [5:0] UID_LEN = 6'd16;
    localparam logic [5:0] UID_PAIR_LEN = 6'd32;
    localparam logic [4:0] UID_COPIES = 5'd16;
    // partial programming limit per page
    localparam logic [2:0] MAX_PARTIAL_PROG = 3'd4;
    // strobe timing: minimum phase length in nanoseconds; each phase lasts T_PHASE_CYC + 1 clock cycles
    localparam int CLK_NS = 8;
    localparam int T_PHASE_NS = 25;
    localparam logic [3:0] T_PHASE_CYC = 4'((T_PHASE_NS + CLK_NS - 1) / CLK_NS);
endpackage : nsh_pkg

// >>> nsh_uid_mem.sv
// small memory holding one unique-id copy with registered read data
module nsh_uid_mem (
    // clock
    input wire logic i_clk_sys,
    // write port
    input wire logic i_we,
    input wire logic [4:0] i_waddr,
    input wire logic [7:0] i_wdata,
    // read port
    input wire logic [4:0] i_raddr,
    output logic [7:0] o_rdata
);
    logic [7:0] mem_ff [0:31];

    // storage write and registered read
    always_ff @(posedge i_clk_sys) begin
        if (i_we) begin
            mem_ff[i_waddr] <= i_wdata;
        end
        o_rdata <= mem_ff[i_raddr];
    end
endmodule // nsh_uid_mem

// >>> nsh_host.sv
// host controller that drives the nand status, id, parameter and program checks
//
// Function
// - status mode persists; read mode command resumes data from initial column.
// - host sends three row cycles after enhanced status command.
// - after ready host issues read mode command before taking data; the host reads data straight after ready, with no read mode command.
// - enhanced status is not issued while otp mode is enabled.
// - accept id copy only if id xor complement is all ones.
// - pages in a block are programmed in ascending order.
// - a page is partially programmed at most four times before erase.
// - no bit is programmed twice without erase between; the host tracks no bits and only limits each page to four partial programs.
// - during program only status read and reset commands are issued.
module nsh_host
    import nsh_pkg::*;
(
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // nand pins
    output logic o_ce_n,
    output logic o_cle,
    output logic o_ale,
    output logic o_we_n,
    output logic o_read_strobe_n,
    input wire logic i_ready_busy_line,
    input wire logic [7:0] i_io,
    output logic [7:0] o_io,
    output logic o_io_oe
);
    import nsh_pkg::*;

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_CMD = 4'h1,
        ST_ADDR = 4'h2,
        ST_WAIT = 4'h3,
        ST_READ = 4'h4,
        ST_DONE = 4'h5
    } nsh_state_e;

    // synchronised reset
    logic rst_s1_ff;
    logic rst_n;
    always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_s1_ff <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_ff <= 1'b1;
            rst_n <= rst_s1_ff;
        end
    end

    nsh_state_e state_ff;
    logic [2:0] op_ff;
    logic busy_ff;
    logic err_ff;
    logic [23:0] row_ff;
    logic [7:0] cmd_ff;
    logic [1:0] addr_cnt_ff;
    logic [9:0] byte_cnt_ff;
    logic [3:0] tim_ff;
    logic phase_ff;
    logic [7:0] status_ff;
    logic [7:0] vrev_lo_ff;
    logic [15:0] tprog_ff;
    logic [15:0] terase_ff;
    logic [15:0] tread_ff;
    logic [15:0] vrev_ff;
    logic [7:0] tprog_lo_ff;
    logic [7:0] terase_lo_ff;
    logic [7:0] tread_lo_ff;
    logic uid_ok_ff;
    logic uid_done_ff;
    logic [4:0] uid_copy_ff;
    logic [7:0] uid_acc_ff;
    logic otp_en_ff;
    logic in_prog_ff;
    logic [23:0] last_page_ff;
    logic last_valid_ff;
    logic [2:0] partial_cnt_ff;
    logic prog_ok_ff;
    logic in_status_mode_ff;

    // wishbone decode
    wire wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;
    wire wb_wr = wb_req && i_wb_we;
    wire sel_ctrl = i_wb_adr == ADDR_CTRL;
    wire sel_row = i_wb_adr == ADDR_ROW;
    wire sel_prog = i_wb_adr == ADDR_PROG;
    wire go = wb_wr && sel_ctrl && i_wb_sel[3] && i_wb_dat[CTRL_GO_BIT] && !busy_ff;
    wire [2:0] go_op = i_wb_dat[CTRL_OP_LSB +: CTRL_OP_W];

    // command sent for each opcode
    function automatic logic [7:0] op_cmd(input logic [2:0] op);
        case (op)
            OP_STATUS: op_cmd = CMD_STATUS;
            OP_STATUS_ENH: op_cmd = CMD_STATUS_ENH;
            OP_READ_MODE: op_cmd = CMD_READ_MODE;
            OP_UID_CHECK: op_cmd = CMD_UNIQUE_ID;
            OP_PARAM_TIMES: op_cmd = CMD_PARAM;
            default: op_cmd = CMD_RESET;
        endcase
    endfunction

    // only status or reset while programming
    wire prog_block = in_prog_ff && !(go_op == OP_STATUS || go_op == OP_RESET);
    // no enhanced status in otp mode
    wire otp_block = otp_en_ff && go_op == OP_STATUS_ENH;
    wire op_refused = prog_block || otp_block || go_op == OP_PROG_CHECK || go_op == 3'h0;

    // ascending page order, partial program limit
    wire [23:0] prog_page = i_wb_dat[23:0];
    wire same_page = last_valid_ff && prog_page == last_page_ff;
    wire ascend_ok = !last_valid_ff || prog_page > last_page_ff;
    // reprogramming a page beyond its partial budget would rewrite bits
    wire partial_ok = same_page && partial_cnt_ff < MAX_PARTIAL_PROG;
    wire prog_chk = wb_wr && sel_prog;
    wire prog_erase = prog_chk && i_wb_dat[31];

    // read data select
    wire [31:0] rd_mux =
        (i_wb_adr == ADDR_CTRL) ? {busy_ff, 26'h0, err_ff, 1'b0, op_ff} :
        (i_wb_adr == ADDR_STAT) ? {8'h0, in_status_mode_ff, otp_en_ff, in_prog_ff, prog_ok_ff,
                                   uid_done_ff, uid_ok_ff, 2'h0, 8'h0, status_ff} :
        (i_wb_adr == ADDR_ROW) ? {8'h0, row_ff} :
        (i_wb_adr == ADDR_RESULT) ? {terase_ff, tprog_ff} :
        (i_wb_adr == ADDR_UID) ? {11'h0, uid_copy_ff, 16'h0} :
        (i_wb_adr == ADDR_PARAM) ? {vrev_ff, tread_ff} :
        (i_wb_adr == ADDR_PROG) ? {5'h0, partial_cnt_ff, last_page_ff} : 32'h0;

    // wishbone ack and read data, one cycle after request
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= wb_req;
            o_wb_dat <= wb_req ? rd_mux : 32'h0;
        end
    end

    // software configuration registers
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            row_ff <= 24'h0;
            otp_en_ff <= 1'b0;
            in_prog_ff <= 1'b0;
        end else begin
            if (wb_wr && sel_row) begin
                row_ff <= i_wb_dat[23:0];
            end
            if (wb_wr && i_wb_adr == ADDR_STAT) begin
                otp_en_ff <= i_wb_dat[22];
                in_prog_ff <= i_wb_dat[21];
            end
        end
    end

    // program order bookkeeping
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            last_page_ff <= 24'h0;
            last_valid_ff <= 1'b0;
            partial_cnt_ff <= 3'h0;
            prog_ok_ff <= 1'b0;
        end else if (prog_erase) begin
            last_valid_ff <= 1'b0;
            partial_cnt_ff <= 3'h0;
            prog_ok_ff <= 1'b1;
        end else if (prog_chk) begin
            prog_ok_ff <= ascend_ok || partial_ok;
            if (ascend_ok) begin
                last_page_ff <= prog_page;
                last_valid_ff <= 1'b1;
                partial_cnt_ff <= 3'h1;
            end else if (partial_ok) begin
                partial_cnt_ff <= partial_cnt_ff + 3'h1;
            end
        end
    end

    // strobe phase timer
    wire tim_done = tim_ff == 4'h0;
    wire [1:0] n_addr = (op_ff == OP_STATUS_ENH) ? 2'd3 : 2'd1;
    wire need_addr = op_ff == OP_STATUS_ENH || op_ff == OP_UID_CHECK || op_ff == OP_PARAM_TIMES;
    wire need_wait = op_ff == OP_UID_CHECK || op_ff == OP_PARAM_TIMES || op_ff == OP_RESET;
    wire need_read = op_ff == OP_STATUS || op_ff == OP_STATUS_ENH ||
                     op_ff == OP_UID_CHECK || op_ff == OP_PARAM_TIMES;
    wire [9:0] last_byte = (op_ff == OP_PARAM_TIMES) ? PP_VREV + 10'd1 :
                           (op_ff == OP_UID_CHECK) ? 10'd511 : 10'd0;
    // three row cycles carry page, plane and block
    wire [7:0] addr_byte = (op_ff == OP_STATUS_ENH) ? row_ff[8*addr_cnt_ff +: 8] : 8'h00;
    wire [4:0] uid_pos = byte_cnt_ff[4:0];
    wire [7:0] uid_rd;
    // id half stored at its own sample edge; complement byte k meets stored byte k-16
    wire uid_we = state_ff == ST_READ && !phase_ff && tim_done && op_ff == OP_UID_CHECK && !uid_pos[4];
    wire uid_byte_ok = (uid_rd ^ i_io) == 8'hFF;

    nsh_uid_mem u_mem (
        .i_clk_sys(i_clk_sys),
        .i_we(uid_we),
        .i_waddr(uid_pos),
        .i_wdata(i_io),
        .i_raddr({1'b0, uid_pos[3:0]}),
        .o_rdata(uid_rd)
    );

    // main sequencer
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= ST_IDLE;
            op_ff <= 3'h0;
            busy_ff <= 1'b0;
            err_ff <= 1'b0;
            cmd_ff <= 8'h0;
            addr_cnt_ff <= 2'h0;
            byte_cnt_ff <= 10'h0;
            tim_ff <= 4'h0;
            phase_ff <= 1'b0;
            status_ff <= 8'h0;
            tprog_lo_ff <= 8'h0;
            terase_lo_ff <= 8'h0;
            tread_lo_ff <= 8'h0;
            vrev_lo_ff <= 8'h0;
            tprog_ff <= 16'h0;
            terase_ff <= 16'h0;
            tread_ff <= 16'h0;
            vrev_ff <= 16'h0;
            uid_ok_ff <= 1'b0;
            uid_done_ff <= 1'b0;
            uid_copy_ff <= 5'h0;
            uid_acc_ff <= 8'hFF;
            in_status_mode_ff <= 1'b0;
            o_ce_n <= 1'b1;
            o_cle <= 1'b0;
            o_ale <= 1'b0;
            o_we_n <= 1'b1;
            o_read_strobe_n <= 1'b1;
            o_io <= 8'h0;
            o_io_oe <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    o_ce_n <= 1'b1;
                    if (go) begin
                        err_ff <= op_refused;
                        if (!op_refused) begin
                            op_ff <= go_op;
                            cmd_ff <= op_cmd(go_op);
                            busy_ff <= 1'b1;
                            state_ff <= ST_CMD;
                            tim_ff <= T_PHASE_CYC;
                            phase_ff <= 1'b0;
                            uid_done_ff <= go_op == OP_UID_CHECK ? 1'b0 : uid_done_ff;
                            uid_ok_ff <= go_op == OP_UID_CHECK ? 1'b0 : uid_ok_ff;
                            uid_copy_ff <= go_op == OP_UID_CHECK ? 5'h0 : uid_copy_ff;
                        end
                    end
                end
                ST_CMD: begin
                    o_ce_n <= 1'b0;
                    o_cle <= 1'b1;
                    o_io_oe <= 1'b1;
                    o_io <= cmd_ff;
                    o_we_n <= phase_ff;
                    tim_ff <= tim_done ? T_PHASE_CYC : tim_ff - 4'h1;
                    if (tim_done) begin
                        phase_ff <= !phase_ff;
                        if (phase_ff) begin
                            o_cle <= 1'b0;
                            addr_cnt_ff <= 2'h0;
                            byte_cnt_ff <= 10'h0;
                            // status mode entered by status, left by any other command
                            in_status_mode_ff <= op_ff == OP_STATUS || op_ff == OP_STATUS_ENH;
                            state_ff <= need_addr ? ST_ADDR : need_wait ? ST_WAIT :
                                        need_read ? ST_READ : ST_DONE;
                        end
                    end
                end
                ST_ADDR: begin
                    o_ale <= 1'b1;
                    o_io <= addr_byte;
                    o_we_n <= phase_ff;
                    tim_ff <= tim_done ? T_PHASE_CYC : tim_ff - 4'h1;
                    if (tim_done) begin
                        phase_ff <= !phase_ff;
                        if (phase_ff) begin
                            addr_cnt_ff <= addr_cnt_ff + 2'h1;
                            if (addr_cnt_ff == n_addr - 2'd1) begin
                                o_ale <= 1'b0;
                                o_io_oe <= 1'b0;
                                state_ff <= need_wait ? ST_WAIT : ST_READ;
                            end
                        end
                    end
                end
                ST_WAIT: begin
                    // ready line gates data access; wait for ready before data
                    o_io_oe <= 1'b0;
                    tim_ff <= tim_done ? 4'h0 : tim_ff - 4'h1;
                    if (tim_done && i_ready_busy_line) begin
                        state_ff <= need_read ? ST_READ : ST_DONE;
                        tim_ff <= T_PHASE_CYC;
                    end
                end
                ST_READ: begin
                    o_io_oe <= 1'b0;
                    // status holds with strobe low; read strobe pulses per byte
                    o_read_strobe_n <= phase_ff;
                    tim_ff <= tim_done ? T_PHASE_CYC : tim_ff - 4'h1;
                    if (tim_done) begin
                        phase_ff <= !phase_ff;
                        if (!phase_ff) begin
                            // sample at end of strobe-low phase
                            byte_cnt_ff <= byte_cnt_ff + 10'd1;
                            if (op_ff == OP_STATUS || op_ff == OP_STATUS_ENH) begin
                                status_ff <= i_io;
                            end
                            // little-endian timing fields, only from the parameter page
                            if (op_ff == OP_PARAM_TIMES) begin
                                if (byte_cnt_ff == PP_TPROG) tprog_lo_ff <= i_io;
                                if (byte_cnt_ff == PP_TPROG + 10'd1) tprog_ff <= {i_io, tprog_lo_ff};
                                if (byte_cnt_ff == PP_TERASE) terase_lo_ff <= i_io;
                                if (byte_cnt_ff == PP_TERASE + 10'd1) terase_ff <= {i_io, terase_lo_ff};
                                if (byte_cnt_ff == PP_TREAD) tread_lo_ff <= i_io;
                                if (byte_cnt_ff == PP_TREAD + 10'd1) tread_ff <= {i_io, tread_lo_ff};
                                if (byte_cnt_ff == PP_VREV) vrev_lo_ff <= i_io;
                                if (byte_cnt_ff == PP_VREV + 10'd1) vrev_ff <= {i_io, vrev_lo_ff};
                            end
                            // xor id with complement, try next copy on failure
                            if (op_ff == OP_UID_CHECK && !uid_done_ff && uid_pos[4]) begin
                                if (uid_pos == 5'd16) begin
                                    uid_acc_ff <= uid_byte_ok ? 8'hFF : 8'h00;
                                end else if (!uid_byte_ok) begin
                                    uid_acc_ff <= 8'h00;
                                end
                                if (uid_pos == 5'd31) begin
                                    if (uid_acc_ff == 8'hFF && uid_byte_ok) begin
                                        uid_ok_ff <= 1'b1;
                                        uid_done_ff <= 1'b1;
                                    end else begin
                                        // index moves on only past a rejected copy
                                        uid_copy_ff <= uid_copy_ff + 5'd1;
                                        if (byte_cnt_ff[8:5] == 4'hF) uid_done_ff <= 1'b1;
                                    end
                                end
                            end
                            // strobe rises in the done state so the last low phase keeps its length
                            if (byte_cnt_ff == last_byte) begin
                                state_ff <= ST_DONE;
                            end
                        end
                    end
                end
                ST_DONE: begin
                    o_ce_n <= 1'b1;
                    o_read_strobe_n <= 1'b1;
                    o_we_n <= 1'b1;
                    o_io_oe <= 1'b0;
                    busy_ff <= 1'b0;
                    if (op_ff == OP_UID_CHECK) uid_copy_ff <= uid_copy_ff;
                    state_ff <= ST_IDLE;
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // nsh_host

// >>> nsh_host_checker.sv
// checker watching the host controller's bus and nand strobe ports
module nsh_host_checker (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset_n,
    // wishbone
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic [31:0] o_wb_dat,
    input wire logic o_wb_ack,
    // nand strobes
    input wire logic o_ce_n,
    input wire logic o_cle,
    input wire logic o_ale,
    input wire logic o_we_n,
    input wire logic o_read_strobe_n,
    input wire logic [7:0] o_io,
    input wire logic o_io_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_reset_n);
    // one strobe phase low, then high again
    sequence we_phase;
        !o_we_n [*5] ##1 o_we_n;
    endsequence
    sequence re_phase;
        !o_read_strobe_n [*5] ##1 o_read_strobe_n;
    endsequence
    ack_one_cycle_a: assert property (o_wb_ack |=> !o_wb_ack) else $error("ack longer than one cycle");
    ack_latency_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("ack not one cycle after request");
    dat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0) else $error("read data outside ack");
    strobe_select_a: assert property (o_ce_n |-> o_we_n && o_read_strobe_n) else $error("strobe while deselected");
    read_turn_a: assert property (!o_read_strobe_n |-> !o_io_oe) else $error("host drives io during read");
    latch_excl_a: assert property (o_cle |-> !o_ale) else $error("command and address latch together");
    we_len_a: assert property ($fell(o_we_n) |-> we_phase) else $error("write strobe phase length");
    re_len_a: assert property ($fell(o_read_strobe_n) |-> re_phase) else $error("read strobe phase length");
    we_data_a: assert property (!o_we_n && !$fell(o_we_n) |-> o_io_oe && $stable(o_io))
        else $error("io moved under write strobe");
endmodule // nsh_host_checker

bind nsh_host nsh_host_checker chk (.i_clk_sys(i_clk_sys), .i_reset_n(i_reset_n), .i_wb_cyc(i_wb_cyc),
    .i_wb_stb(i_wb_stb), .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .o_ce_n(o_ce_n), .o_cle(o_cle),
    .o_ale(o_ale), .o_we_n(o_we_n), .o_read_strobe_n(o_read_strobe_n), .o_io(o_io), .o_io_oe(o_io_oe));

// >>> nsh_nand_model.sv
// behavioural nand target answering the host's strobes
module nsh_nand_model
    import nsh_pkg::*;
(
    // host strobes
    input wire logic i_ce_n,
    input wire logic i_cle,
    input wire logic i_ale,
    input wire logic i_we_n,
    input wire logic i_re_n,
    input wire logic [7:0] i_io,
    // bench controls
    input wire logic i_rdy,
    input wire logic i_fail,
    input wire logic i_wp_n,
    // target outputs and observation
    output logic [7:0] o_io,
    output logic o_rb,
    output logic [7:0] o_cmd,
    output logic [7:0] o_n_enh,
    output logic [7:0] o_n_par,
    output logic [23:0] o_row
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [9:0] rd_cnt = 10'h000;
    logic [9:0] col_base = 10'h000;
    // column is strobes seen since the last command
    wire [9:0] col = rd_cnt - col_base;
    logic [7:0] q;
    initial begin
        o_cmd = 8'hFF;
        o_n_enh = 8'h00;
        o_n_par = 8'h00;
        o_row = 24'h0;
    end
    // latch commands and row cycles on the write strobe; new command restarts column
    always @(posedge i_we_n) begin
        if (!i_ce_n && i_cle) begin
            o_cmd <= i_io;
            col_base <= rd_cnt;
            o_row <= 24'h0;
            o_n_enh <= o_n_enh + 8'(i_io == CMD_STATUS_ENH);
            o_n_par <= o_n_par + 8'(i_io == CMD_PARAM);
        end else if (!i_ce_n && i_ale) begin
            o_row <= {i_io, o_row[23:8]};
        end
    end
    // column advances after each read strobe
    always @(posedge i_re_n) if (!i_ce_n) rd_cnt <= rd_cnt + 10'h001;
    // status; parameter page; id pairs, first copy bad
    always_comb begin
        q = 8'h00;
        if (o_cmd == CMD_STATUS || o_cmd == CMD_STATUS_ENH) begin
            q = {i_wp_n, i_rdy, i_rdy, 3'h0, i_fail & (o_cmd == CMD_STATUS_ENH), i_fail};
        end else if (o_cmd == CMD_UNIQUE_ID) begin
            q = (col[8:0] == 9'h000) ? 8'h00 : 8'hA0 + 8'(col[3:0]);
            if (col[4]) q = ~q;
        end else if (o_cmd == CMD_PARAM) begin
            case (col[7:0])
                8'd133: q = 8'hBC;
                8'd134: q = 8'h02;
                8'd135: q = 8'h10;
                8'd136: q = 8'h27;
                8'd137: q = 8'h19;
                8'd164: q = 8'h01;
                default: q = 8'h00;
            endcase
        end
    end
    // byte stands while selected and read strobe low, inverted otherwise
    assign o_io = (!i_ce_n && !i_re_n) ? q : ~q;
    assign o_rb = i_rdy;
endmodule // nsh_nand_model

// >>> nsh_host_tb.sv
// testbench driving the host controller over wishbone against the nand model
module nsh_host_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import nsh_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic rdy = 1'b1, fail = 1'b0, wp_n = 1'b1;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rd;
    wire logic [31:0] rdat;
    wire logic ack, ce_n, cle, ale, we_n, re_n, rb, oe;
    wire logic [7:0] io_h, io_d, lcmd, n_enh, n_par;
    wire logic [23:0] row;
    int mismatches = 0, checked = 0;
    nsh_host DUT (.i_clk_sys(clk), .i_reset_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we),
        .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat), .o_wb_ack(ack), .o_ce_n(ce_n),
        .o_cle(cle), .o_ale(ale), .o_we_n(we_n), .o_read_strobe_n(re_n), .i_ready_busy_line(rb),
        .i_io(io_d), .o_io(io_h), .o_io_oe(oe));
    nsh_nand_model nand_m (.i_ce_n(ce_n), .i_cle(cle), .i_ale(ale), .i_we_n(we_n), .i_re_n(re_n),
        .i_io(io_h), .i_rdy(rdy), .i_fail(fail), .i_wp_n(wp_n), .o_io(io_d), .o_rb(rb), .o_cmd(lcmd),
        .o_n_enh(n_enh), .o_n_par(n_par), .o_row(row));
    // clock of 8 ns
    initial begin
        forever #4 clk = ~clk;
    end
    // one classic wishbone cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {cyc, stb, we, adr, wdat, sel} <= {1'b1, 1'b1, w, a, d, 4'hF};
        do begin
            @(posedge clk);
        end while (ack !== 1'b1);
        rd = rdat;
        {cyc, stb, we} <= 3'b000;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checked++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        cmp(rd & m, e);
    endtask
    // start an operation and poll busy under a bound
    task automatic op(input logic [2:0] c);
        int n;
        wb(1'b1, ADDR_CTRL, 32'h8000_0000 | 32'(c));
        n = 0;
        do begin
            wb(1'b0, ADDR_CTRL, 32'h0);
            n++;
        end while (rd[31] !== 1'b0 && n < 4000);
        if (rd[31] !== 1'b0) mismatches++;
    endtask
    task automatic give_verdict();
        if (mismatches == 0 && checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // watchdog
    initial begin
        #600us;
        mismatches++;
        give_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        chk(8'h40, 32'hFFFF_FFFF, 32'h0);
        op(OP_STATUS);
        chk(ADDR_STAT, 32'h0080_00FF, 32'h0080_00E0);
        {rdy, fail, wp_n} <= 3'b010;
        op(OP_STATUS);
        chk(ADDR_STAT, 32'hFF, 32'h01);
        wb(1'b1, ADDR_ROW, 32'h0003_0201);
        op(OP_STATUS_ENH);
        chk(ADDR_STAT, 32'hFF, 32'h03);
        cmp(32'(row), 32'h0003_0201);
        {rdy, fail, wp_n} <= 3'b101;
        op(OP_READ_MODE);
        cmp(32'(lcmd), 32'(CMD_READ_MODE));
        chk(ADDR_STAT, 32'h0080_0000, 32'h0);
        op(OP_PARAM_TIMES);
        chk(ADDR_RESULT, 32'hFFFF_FFFF, 32'h2710_02BC);
        chk(ADDR_PARAM, 32'hFFFF_FFFF, 32'h0001_0019);
        op(OP_UID_CHECK);
        chk(ADDR_STAT, 32'h000C_0000, 32'h000C_0000);
        chk(ADDR_UID, 32'h001F_0000, 32'h0001_0000);
        wb(1'b1, ADDR_STAT, 32'h0040_0000);
        op(OP_STATUS_ENH);
        cmp(32'(n_enh), 32'h1);
        chk(ADDR_CTRL, 32'h10, 32'h10);
        wb(1'b1, ADDR_STAT, 32'h0020_0000);
        op(OP_PARAM_TIMES);
        cmp(32'(n_par), 32'h1);
        op(OP_RESET);
        cmp(32'(lcmd), 32'(CMD_RESET));
        op(OP_STATUS);
        cmp(32'(lcmd), 32'(CMD_STATUS));
        wb(1'b1, ADDR_STAT, 32'h0);
        wb(1'b1, ADDR_PROG, 32'h8000_0000);
        for (int i = 0; i < 5; i++) begin
            wb(1'b1, ADDR_PROG, 32'h5);
            chk(ADDR_STAT, 32'h0010_0000, (i < 4) ? 32'h0010_0000 : 32'h0);
        end
        wb(1'b1, ADDR_PROG, 32'h8000_0000);
        wb(1'b1, ADDR_PROG, 32'h2);
        chk(ADDR_PROG, 32'h07FF_FFFF, 32'h0100_0002);
        wb(1'b1, ADDR_PROG, 32'h1);
        chk(ADDR_STAT, 32'h0010_0000, 32'h0);
        give_verdict();
    end
endmodule // nsh_host_tb
